// ---- pkg/dac_one_pkg.sv ----
// Constants and types shared by the channel-one converter control block.
`default_nettype none
package dac_one_pkg;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] SWTRIG_OFFSET = 8'h04;
	localparam logic [7:0] HOLD_OFFSET = 8'h08;
	localparam logic [7:0] OUT_OFFSET = 8'h2c;
	localparam int ENABLE_BIT = 0;
	localparam int BUFOFF_BIT = 1;
	localparam int TRIGON_BIT = 2;
	localparam int TSRC_LSB = 3;
	localparam int WAVE_LSB = 6;
	localparam int MASK_LSB = 8;
	localparam int DMA_BIT = 12;
	localparam int SWTRIG_BIT = 0;
	localparam int CTRL_BITS = 13;
	localparam int DATA_BITS = 12;
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 13'h0000;
	localparam logic [DATA_BITS-1:0] DATA_RESET = 12'h000;
	localparam logic [3:0] SEL_SATURATE = 4'hb;
	localparam logic [DATA_BITS-1:0] LIMIT_MAX = 12'hfff;
	localparam logic [DATA_BITS-1:0] LIMIT_RESET = 12'h001;
	localparam int HW_TRIG_CYCLES = 3;
	typedef enum logic [2:0] {
		SRC_TIMER_SIX = 3'b000,
		SRC_TIMER_THREE = 3'b001,
		SRC_TIMER_SEVEN = 3'b010,
		SRC_UNUSED_011 = 3'b011,
		SRC_TIMER_TWO = 3'b100,
		SRC_RESERVED = 3'b101,
		SRC_EXT_LINE_NINE = 3'b110,
		SRC_SOFTWARE = 3'b111
	} trig_src_e;
	typedef enum logic [1:0] {
		WAVE_NONE = 2'b00,
		WAVE_NOISE = 2'b01,
		WAVE_TRI_A = 2'b10,
		WAVE_TRI_B = 2'b11
	} wave_mode_e;
endpackage : dac_one_pkg
`default_nettype wire

// ---- core/dac_channel_one_control.sv ----
// AHB-Lite register slave and holding-to-output transfer for converter channel one.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dac_channel_one_control
	import dac_one_pkg::*;
#(
	parameter int TRIG_DELAY = HW_TRIG_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timer_six_trigger_out,
	input wire logic timer_three_trigger_out,
	input wire logic timer_seven_trigger_out,
	input wire logic timer_two_trigger_out,
	input wire logic ext_line_nine,
	output logic chan_one_enable,
	output logic chan_one_buffer_off,
	output logic noise_on,
	output logic triangle_on,
	output logic [DATA_BITS-1:0] wave_limit,
	output logic dma_request,
	output logic [DATA_BITS-1:0] output_data_reg
);

	// The shift pipe needs two stages at least; the assertions are written for three.
	if (TRIG_DELAY < 2 || TRIG_DELAY > 8) begin : g_delay_check
		$error("TRIG_DELAY must lie between 2 and 8");
	end

	logic wr_pend;
	logic [7:0] wr_addr;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_ok;
	logic [CTRL_BITS-1:0] ctrl;
	logic [CTRL_BITS-1:0] next_ctrl;
	logic next_noise_on;
	logic next_triangle_on;
	logic [DATA_BITS-1:0] next_wave_limit;
	logic [DATA_BITS-1:0] holding_data_reg;
	logic [DATA_BITS-1:0] next_holding;
	logic [DATA_BITS-1:0] next_output;
	logic untrig_pend;
	logic next_untrig_pend;
	logic sw_pend;
	logic next_sw_pend;
	logic [TRIG_DELAY-1:0] pipe;
	logic [TRIG_DELAY-1:0] next_pipe;
	logic next_dma_request;
	logic wr_ctrl;
	logic wr_hold;
	logic wr_swtrig;
	logic hw_hit;
	logic sw_hit;
	logic load;
	logic chan_one_trigger_on;
	logic chan_one_dma_on;
	trig_src_e chan_one_trigger_source;
	wave_mode_e chan_one_wave_mode;
	logic [3:0] chan_one_mask_amplitude;

	assign chan_one_enable = ctrl[ENABLE_BIT];
	assign chan_one_buffer_off = ctrl[BUFOFF_BIT];
	assign chan_one_trigger_on = ctrl[TRIGON_BIT];
	assign chan_one_dma_on = ctrl[DMA_BIT];
	assign chan_one_trigger_source = trig_src_e'(ctrl[TSRC_LSB+:3]);
	assign chan_one_wave_mode = wave_mode_e'(ctrl[WAVE_LSB+:2]);
	assign chan_one_mask_amplitude = ctrl[MASK_LSB+:4];

	// Address phase is captured here; the data phase completes with zero wait states.
	always_comb begin
		addr_ok = hsel && htrans[1] && hready;
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
		next_hrdata = hrdata;
		if (addr_ok && !hwrite) begin
			// Reading next values keeps a read right after a write coherent.
			case (haddr[7:0])
				CTRL_OFFSET: next_hrdata = {19'h00000, next_ctrl};
				HOLD_OFFSET: next_hrdata = {20'h00000, next_holding};
				OUT_OFFSET: next_hrdata = {20'h00000, next_output};
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	// Ready and response are registered constants, so the bus never waits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Writes act in the data phase, while the write data stands on the bus.
	assign wr_ctrl = wr_pend && (wr_addr == CTRL_OFFSET);
	assign wr_hold = wr_pend && (wr_addr == HOLD_OFFSET);
	assign wr_swtrig = wr_pend && (wr_addr == SWTRIG_OFFSET) && hwdata[SWTRIG_BIT];

	// The generator limit serves as LFSR mask and triangle amplitude alike.
	always_comb begin
		next_ctrl = wr_ctrl ? hwdata[CTRL_BITS-1:0] : ctrl;
		next_noise_on = (wave_mode_e'(next_ctrl[WAVE_LSB+:2]) == WAVE_NOISE);
		next_triangle_on = next_ctrl[WAVE_LSB+1];
		if (next_ctrl[MASK_LSB+:4] >= SEL_SATURATE) begin
			next_wave_limit = LIMIT_MAX;
		end else begin
			next_wave_limit = DATA_BITS'((13'h0002 << next_ctrl[MASK_LSB+:4]) - 13'h0001);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
			noise_on <= 1'b0;
			triangle_on <= 1'b0;
			wave_limit <= LIMIT_RESET;
		end else if (ce) begin
			ctrl <= next_ctrl;
			noise_on <= next_noise_on;
			triangle_on <= next_triangle_on;
			wave_limit <= next_wave_limit;
		end
	end

	// Source selection for hardware triggers; unlisted codes never fire.
	always_comb begin
		hw_hit = 1'b0;
		if (chan_one_trigger_on) begin
			case (chan_one_trigger_source)
				SRC_TIMER_SIX: hw_hit = timer_six_trigger_out;
				SRC_TIMER_THREE: hw_hit = timer_three_trigger_out;
				SRC_TIMER_SEVEN: hw_hit = timer_seven_trigger_out;
				SRC_TIMER_TWO: hw_hit = timer_two_trigger_out;
				SRC_EXT_LINE_NINE: hw_hit = ext_line_nine;
				default: hw_hit = 1'b0;
			endcase
		end
	end

	assign sw_hit = wr_swtrig && chan_one_trigger_on && (chan_one_trigger_source == SRC_SOFTWARE);
	// A hardware load already in the pipe still lands if triggering is switched off.
	assign load = untrig_pend || sw_pend || pipe[TRIG_DELAY-1];

	always_comb begin
		next_holding = wr_hold ? hwdata[DATA_BITS-1:0] : holding_data_reg;
		next_untrig_pend = wr_hold && !chan_one_trigger_on;
		next_sw_pend = sw_hit;
		next_pipe = {pipe[TRIG_DELAY-2:0], hw_hit};
		next_output = load ? holding_data_reg : output_data_reg;
		next_dma_request = (sw_pend || pipe[TRIG_DELAY-1]) && chan_one_dma_on;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			holding_data_reg <= DATA_RESET;
			output_data_reg <= DATA_RESET;
			untrig_pend <= 1'b0;
			sw_pend <= 1'b0;
			pipe <= '0;
			dma_request <= 1'b0;
		end else if (ce) begin
			holding_data_reg <= next_holding;
			output_data_reg <= next_output;
			untrig_pend <= next_untrig_pend;
			sw_pend <= next_sw_pend;
			pipe <= next_pipe;
			dma_request <= next_dma_request;
		end
	end

	// The assertions below assume the default trigger delay of three cycles.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	enable_write_a: assert property (wr_ctrl && ce |=> chan_one_enable == $past(hwdata[0]))
		else $error("enable bit did not follow the control write");
	buffer_write_a: assert property (wr_ctrl && ce |=> chan_one_buffer_off == $past(hwdata[1]))
		else $error("buffer-off bit did not follow the control write");
	untrig_copy_a: assert property ((wr_hold && !chan_one_trigger_on && ce) ##1 ce ##1 ce
		|-> output_data_reg == $past(hwdata[11:0], 2))
		else $error("untriggered holding write not copied after one cycle");
	hw_trig_delay_a: assert property ((hw_hit && ce) ##1 ce ##1 ce ##1 ce
		|=> output_data_reg == $past(holding_data_reg))
		else $error("hardware trigger transfer not done after three cycles");
	sw_trig_delay_a: assert property ((sw_hit && ce) ##1 ce
		|=> output_data_reg == $past(holding_data_reg))
		else $error("software trigger transfer not done after one cycle");
	out_write_ignored_a: assert property (!load |=> $stable(output_data_reg))
		else $error("output data changed without a transfer");
	trig_off_quiet_a: assert property (!chan_one_trigger_on && ce |=> !pipe[0] && !sw_pend)
		else $error("trigger accepted while triggering is off");
	dma_gate_a: assert property (dma_request |-> $past(chan_one_dma_on))
		else $error("DMA request issued while DMA is off");
	limit_sat_a: assert property (chan_one_mask_amplitude >= SEL_SATURATE
		|-> wave_limit == LIMIT_MAX)
		else $error("selector at or above eleven did not saturate");
	noise_mode_a: assert property (noise_on == (chan_one_wave_mode == WAVE_NOISE))
		else $error("noise flag does not match the wave field");
	trig_write_a: assert property (wr_ctrl && ce |=>
		chan_one_trigger_on == $past(hwdata[TRIGON_BIT]))
		else $error("trigger enable bit did not follow the control write");
	dma_write_a: assert property (wr_ctrl && ce |=>
		chan_one_dma_on == $past(hwdata[DMA_BIT]))
		else $error("DMA enable bit did not follow the control write");
	triangle_mode_a: assert property (triangle_on ==
		(chan_one_wave_mode == WAVE_TRI_A || chan_one_wave_mode == WAVE_TRI_B))
		else $error("triangle flag does not match the wave field");
	wave_none_a: assert property (chan_one_wave_mode == WAVE_NONE |->
		!noise_on && !triangle_on)
		else $error("a generator is on while the wave field is zero");
	limit_shape_a: assert property (chan_one_mask_amplitude < SEL_SATURATE |->
		$countones(wave_limit) == chan_one_mask_amplitude + 1
		&& (wave_limit & (wave_limit + 12'h001)) == 12'h000)
		else $error("mask or amplitude is not a run of ones of the selected length");
	dead_source_a: assert property ((chan_one_trigger_source == SRC_RESERVED
		|| chan_one_trigger_source == SRC_UNUSED_011
		|| chan_one_trigger_source == SRC_SOFTWARE) && ce |=> !pipe[0])
		else $error("a source without a hardware line started a transfer");
	sw_src_only_a: assert property (wr_swtrig && ce
		&& chan_one_trigger_source != SRC_SOFTWARE |=> !sw_pend)
		else $error("software trigger accepted with another source selected");
	hold_write_a: assert property (wr_hold && ce |=>
		holding_data_reg == $past(hwdata[DATA_BITS-1:0]))
		else $error("holding register did not take the written data");

	untrig_cov_c: cover property (wr_hold && !chan_one_trigger_on ##1 load);
	hw_trig_cov_c: cover property (hw_hit ##3 load);
	sw_trig_cov_c: cover property (sw_hit ##2 dma_request);
	tri_sat_cov_c: cover property (triangle_on && wave_limit == LIMIT_MAX);
	freeze_cov_c: cover property (load && !ce);

endmodule : dac_channel_one_control
`default_nettype wire

// ---- bench/dac_channel_one_control_tb.sv ----
// Self-checking bench for the channel-one converter control block.
`timescale 1ns/1ps
`default_nettype none
module dac_channel_one_control_tb
	import dac_one_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic hreadyout, hresp, chan_one_enable, chan_one_buffer_off, noise_on, triangle_on;
	logic dma_request;
	logic [DATA_BITS-1:0] wave_limit, output_data_reg, cur;
	logic [4:0] trig = 5'h00;
	logic ce = 1'b1;
	int mismatches = 0;
	int comparisons = 0;
	int srcs[5] = '{0, 1, 2, 4, 6};

	always #2 hclk = ~hclk;

	dac_channel_one_control dac_channel_one_control_i (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .timer_six_trigger_out(trig[0]),
		.timer_three_trigger_out(trig[1]), .timer_seven_trigger_out(trig[2]),
		.timer_two_trigger_out(trig[3]), .ext_line_nine(trig[4]),
		.chan_one_enable(chan_one_enable), .chan_one_buffer_off(chan_one_buffer_off),
		.noise_on(noise_on), .triangle_on(triangle_on), .wave_limit(wave_limit),
		.dma_request(dma_request), .output_data_reg(output_data_reg));

	task automatic close_out;
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("BAD at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Starts just after a rising edge, returns at the edge that ends the data phase.
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(hresp, 0);
	endtask : bus

	// Off-source pulses must be ignored, the selected one loads three edges later.
	task automatic hw(input int k, input logic [11:0] v, input logic d);
		bus(HOLD_OFFSET, 1'b1, {20'h0, v});
		trig <= 5'h1f & ~(5'd1 << k);
		@(posedge hclk);
		trig <= 5'h00;
		repeat (4) @(posedge hclk);
		#1 chk(output_data_reg, cur);
		trig <= 5'd1 << k;
		@(posedge hclk);
		trig <= 5'h00;
		repeat (2) @(posedge hclk);
		#1 chk(output_data_reg, cur);
		@(posedge hclk);
		#1 chk(output_data_reg, v);
		chk(dma_request, d);
		cur = v;
	endtask : hw

	initial begin
		#20000;
		mismatches++;
		close_out();
	end

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(output_data_reg, 0);
		chk(wave_limit, 1);
		bus(CTRL_OFFSET, 1'b0, 0);
		chk(r, 0);
		bus(CTRL_OFFSET, 1'b1, 32'h1003);
		#1 chk({chan_one_enable, chan_one_buffer_off}, 2'b11);
		bus(CTRL_OFFSET, 1'b1, 32'h0);
		#1 chk({chan_one_enable, chan_one_buffer_off}, 2'b00);
		for (int i = 0; i < 16; i++) begin
			bus(CTRL_OFFSET, 1'b1, (i << 8) | ((i % 4) << 6));
			bus(CTRL_OFFSET, 1'b0, 0);
			chk(r, (i << 8) | ((i % 4) << 6));
			chk({noise_on, triangle_on}, {i % 4 == 1, i % 4 >= 2});
			chk(wave_limit, i >= 11 ? 32'hfff : (32'h1 << (i + 1)) - 1);
		end
		bus(CTRL_OFFSET, 1'b1, 32'h1000);
		bus(HOLD_OFFSET, 1'b1, 32'habc);
		#1 chk(output_data_reg, 0);
		@(posedge hclk);
		#1 chk(output_data_reg, 32'habc);
		chk(dma_request, 0);
		cur = 12'habc;
		bus(OUT_OFFSET, 1'b1, 32'h123);
		bus(OUT_OFFSET, 1'b0, 0);
		chk(r, 32'habc);
		bus(8'h40, 1'b0, 0);
		chk(r, 0);
		trig <= 5'h1f;
		repeat (5) @(posedge hclk);
		trig <= 5'h00;
		#1 chk(output_data_reg, cur);
		for (int i = 0; i < 5; i++) begin
			bus(CTRL_OFFSET, 1'b1, 32'h1004 | (srcs[i] << 3));
			hw(i, 12'h100 + i, 1'b1);
		end
		bus(CTRL_OFFSET, 1'b1, 32'h0004);
		hw(0, 12'h055, 1'b0);
		bus(CTRL_OFFSET, 1'b1, 32'h102c);
		bus(HOLD_OFFSET, 1'b1, 32'h777);
		trig <= 5'h1f;
		repeat (5) @(posedge hclk);
		trig <= 5'h00;
		#1 chk(output_data_reg, cur);
		bus(SWTRIG_OFFSET, 1'b1, 32'h1);
		@(posedge hclk);
		#1 chk(output_data_reg, cur);
		bus(CTRL_OFFSET, 1'b1, 32'h103c);
		bus(SWTRIG_OFFSET, 1'b1, 32'h1);
		#1 chk(output_data_reg, cur);
		@(posedge hclk);
		#1 chk(output_data_reg, 32'h777);
		chk(dma_request, 1);
		bus(HOLD_OFFSET, 1'b1, 32'h321);
		bus(SWTRIG_OFFSET, 1'b1, 32'h1);
		ce <= 1'b0;
		repeat (3) @(posedge hclk);
		ce <= 1'b1;
		#1 chk(output_data_reg, 32'h777);
		@(posedge hclk);
		#1 chk(output_data_reg, 32'h321);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(CTRL_OFFSET, 1'b0, 0);
		chk(r, 0);
		#1 chk(output_data_reg, 0);
		chk(wave_limit, 1);
		close_out();
	end
endmodule : dac_channel_one_control_tb
`default_nettype wire
